// >>> logic/pci_bus_request_grant_parking.v
// Request, grant and bus parking for the primary and secondary sides of a bridge
`include "bus_park_regs.vh"

// Behaviour
// - Strap high disables internal secondary arbiter; external arbiter owns the bus.
// - External mode: grant output 0 becomes request, request input 0 becomes grant.
// - External mode: grant low after own request starts transaction next cycle.
// - External mode: grant without own request parks AD, C/BE and parity.
// - External mode: grant outputs 1 to 8 held high.
// - Parking drives AD and C/BE first, parity one cycle later.
// - Park primary only with grant asserted, request deasserted, bus idle.
// - Primary grant removed floats AD, C/BE and parity next cycle; code floats them two cycles after pgnt_reg goes high.
// - Parked primary with pending work may start frame next clock if granted.
// - Internal arbiter: secondary bus parked at last master.
// - Internal arbiter: last grant kept until a new request arrives.
// - Internal arbiter: after reset, secondary bus parked at bridge until traffic begins.
// - Internal arbiter: force-park bit forces secondary parking at bridge; resets to zero.
// - External mode: park secondary only while granted and bus idle.
// - Strap low enables internal arbiter: nine grants from nine requests.
module pci_bus_request_grant_parking #(
    parameter MASTERS = `SEC_MASTERS
) (
    input wire clk_sys_in,
    input wire reset_in,
    input wire central_function_strap_n,
    input wire force_sec_park_in,
    input wire pri_pending_in,
    input wire pri_gnt_n_in,
    input wire pri_frame_n_in,
    input wire pri_irdy_n_in,
    input wire sec_pending_in,
    input wire [MASTERS-1:0] sec_req_n_in,
    input wire sec_frame_n_in,
    input wire sec_irdy_n_in,
    output reg pri_req_n_out,
    output reg pri_frame_n_out,
    output wire pri_ad_cbe_oe_n_out,
    output wire primary_parity_oe_n_out,
    output reg [MASTERS-1:0] sec_gnt_n_out,
    output reg sec_frame_n_out,
    output wire sec_ad_cbe_oe_n_out,
    output wire sec_par_oe_n_out,
    output reg external_mode_out
);
    // Pin synchronisers, three stages; a change counts when stages two and three agree
    reg [2:0] pgnt_s, pframe_s, pirdy_s, sframe_s, sirdy_s, strap_s;
    reg [MASTERS-1:0] sreq_s1, sreq_s2, sreq_s3;
    reg pgnt_reg, pframe_reg, pirdy_reg, sframe_reg, sirdy_reg, strap_reg;
    reg [MASTERS-1:0] sreq_reg;
    reg strap_taken_reg;
    reg force_park_reg;
    always @(posedge clk_sys_in) begin
        if (reset_in) begin
            pgnt_s <= 3'h7;
            pframe_s <= 3'h7;
            pirdy_s <= 3'h7;
            sframe_s <= 3'h7;
            sirdy_s <= 3'h7;
            strap_s <= 3'h0;
            sreq_s1 <= {MASTERS{1'b1}};
            sreq_s2 <= {MASTERS{1'b1}};
            sreq_s3 <= {MASTERS{1'b1}};
            pgnt_reg <= 1'b1;
            pframe_reg <= 1'b1;
            pirdy_reg <= 1'b1;
            sframe_reg <= 1'b1;
            sirdy_reg <= 1'b1;
            strap_reg <= 1'b0;
            sreq_reg <= {MASTERS{1'b1}};
        end else begin
            pgnt_s <= {pgnt_s[1:0], pri_gnt_n_in};
            pframe_s <= {pframe_s[1:0], pri_frame_n_in};
            pirdy_s <= {pirdy_s[1:0], pri_irdy_n_in};
            sframe_s <= {sframe_s[1:0], sec_frame_n_in};
            sirdy_s <= {sirdy_s[1:0], sec_irdy_n_in};
            strap_s <= {strap_s[1:0], central_function_strap_n};
            sreq_s1 <= sec_req_n_in;
            sreq_s2 <= sreq_s1;
            sreq_s3 <= sreq_s2;
            if (pgnt_s[1] == pgnt_s[2]) pgnt_reg <= pgnt_s[2];
            if (pframe_s[1] == pframe_s[2]) pframe_reg <= pframe_s[2];
            if (pirdy_s[1] == pirdy_s[2]) pirdy_reg <= pirdy_s[2];
            if (sframe_s[1] == sframe_s[2]) sframe_reg <= sframe_s[2];
            if (sirdy_s[1] == sirdy_s[2]) sirdy_reg <= sirdy_s[2];
            if (strap_s[1] == strap_s[2]) strap_reg <= strap_s[2];
            sreq_reg <= (sreq_s2 & sreq_s3) | (sreq_reg & (sreq_s2 ^ sreq_s3)) |
                        (~sreq_s2 & ~sreq_s3 & {MASTERS{1'b0}});
        end
    end

    // Strap taken once after it has passed the synchroniser, then frozen
    // Wait covers three sync stages plus the agreement check, else reset level leaks in
    reg [2:0] strap_wait_reg;
    always @(posedge clk_sys_in) begin
        if (reset_in) begin
            strap_wait_reg <= 3'h0;
            strap_taken_reg <= 1'b0;
            external_mode_out <= 1'b0;
            force_park_reg <= `PARK_CFG_RESET;
        end else begin
            force_park_reg <= force_sec_park_in;
            if (!strap_taken_reg) begin
                if (strap_wait_reg == 3'h5) begin
                    strap_taken_reg <= 1'b1;
                    external_mode_out <= strap_reg;
                end else begin
                    strap_wait_reg <= strap_wait_reg + 3'h1;
                end
            end
        end
    end

    wire pri_idle = pframe_reg & pirdy_reg;
    wire sec_idle = sframe_reg & sirdy_reg;
    wire ext_gnt = ~sreq_reg[0];

    // Primary side: request, start one cycle after grant, park when idle
    reg pri_park_reg;
    reg pri_owned_reg;
    always @(posedge clk_sys_in) begin
        if (reset_in) begin
            pri_req_n_out <= 1'b1;
            pri_frame_n_out <= 1'b1;
            pri_park_reg <= 1'b0;
            pri_owned_reg <= 1'b0;
        end else begin
            pri_req_n_out <= ~pri_pending_in;
            pri_frame_n_out <= 1'b1;
            if (pri_owned_reg) begin
                // Single-data-phase framing; the data path ends the transfer
                pri_owned_reg <= 1'b0;
            end else if (pri_pending_in & ~pgnt_reg & pri_idle &
                         (~pri_req_n_out | pri_park_reg)) begin
                pri_frame_n_out <= 1'b0;
                pri_owned_reg <= 1'b1;
            end
            // Grant removal drops parking; enables float on the next cycle
            pri_park_reg <= ~pgnt_reg & pri_req_n_out & pri_idle;
        end
    end

    park_driver pri_drv (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .park_in(pri_park_reg),
        .ad_cbe_oe_n_out(pri_ad_cbe_oe_n_out),
        .par_oe_n_out(primary_parity_oe_n_out)
    );

    // Secondary internal arbiter: lowest-index waiting request wins, grant is sticky
    reg [3:0] owner_reg;
    reg [4:0] idle_cnt_reg;
    reg seen_traffic_reg;
    reg sec_park_reg;
    reg sec_req_out_reg;
    integer i;
    reg [3:0] pick;
    reg pick_valid;
    always @* begin
        pick = 4'h0;
        pick_valid = 1'b0;
        for (i = MASTERS - 1; i >= 0; i = i - 1) begin
            if (!sreq_reg[i]) begin
                pick = i[3:0];
                pick_valid = 1'b1;
            end
        end
    end

    always @(posedge clk_sys_in) begin
        if (reset_in) begin
            sec_gnt_n_out <= {MASTERS{1'b1}};
            sec_frame_n_out <= 1'b1;
            owner_reg <= 4'h0;
            idle_cnt_reg <= 5'h0;
            seen_traffic_reg <= 1'b0;
            sec_park_reg <= 1'b0;
            sec_req_out_reg <= 1'b0;
        end else if (external_mode_out) begin
            // Grant 0 is our request; others held high
            sec_gnt_n_out <= {{(MASTERS-1){1'b1}}, ~sec_pending_in};
            sec_req_out_reg <= sec_pending_in;
            sec_frame_n_out <= ~(sec_req_out_reg & ext_gnt & sec_idle &
                                 sec_frame_n_out);
            sec_park_reg <= ext_gnt & ~sec_req_out_reg & sec_idle;
        end else begin
            sec_frame_n_out <= 1'b1;
            if (!sec_idle) seen_traffic_reg <= 1'b1;
            if (force_park_reg | !seen_traffic_reg) begin
                // Bridge owns the parked bus
                sec_gnt_n_out <= {MASTERS{1'b1}};
                sec_park_reg <= sec_idle;
            end else if (pick_valid && (pick != owner_reg) && sec_idle) begin
                // Drop the old grant a cycle before raising the new one on an idle bus
                sec_gnt_n_out <= {MASTERS{1'b1}};
                owner_reg <= pick;
                sec_park_reg <= 1'b0;
            end else begin
                sec_gnt_n_out <= ~({{(MASTERS-1){1'b0}}, 1'b1} << owner_reg);
                sec_park_reg <= 1'b0;
            end
            idle_cnt_reg <= sec_idle ? idle_cnt_reg : 5'h0;
        end
    end

    park_driver sec_drv (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .park_in(sec_park_reg),
        .ad_cbe_oe_n_out(sec_ad_cbe_oe_n_out),
        .par_oe_n_out(sec_par_oe_n_out)
    );
endmodule // pci_bus_request_grant_parking

// >>> logic/bus_park_regs.vh
// Header: constants for the request, grant and parking logic
`ifndef BUS_PARK_REGS_VH
`define BUS_PARK_REGS_VH
`define SEC_MASTERS 9
`define PARK_CFG_OFFSET 8'h48
`define PARK_CFG_FORCE_BIT 1
`define PARK_CFG_RESET 1'b0
`define PAR_DELAY_CYCLES 1
`define GNT_IDLE_TIMEOUT 5'h10
`endif

// >>> logic/park_driver.v
// Parking driver: AD and C/BE enable first, parity enable one cycle later
module park_driver (
    input wire clk_sys_in,
    input wire reset_in,
    input wire park_in,
    output reg ad_cbe_oe_n_out,
    output reg par_oe_n_out
);
    // Enables are active low; parity lags so it covers settled AD and C/BE
    always @(posedge clk_sys_in) begin
        if (reset_in) begin
            ad_cbe_oe_n_out <= 1'b1;
            par_oe_n_out <= 1'b1;
        end else begin
            ad_cbe_oe_n_out <= ~park_in;
            par_oe_n_out <= ~(park_in & ~ad_cbe_oe_n_out);
        end
    end
endmodule // park_driver

// >>> tb/pci_arbiter_model.sv
// Behavioural PCI bus arbiter facing one request/grant pair
module pci_arbiter_model (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic req_n_in,
    input wire logic park_in,
    input wire logic [1:0] lat_in,
    output logic gnt_n_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] wait_reg;
    // Grant lat_in cycles after a request, or at once when parked here
    always @(posedge clk_in) begin
        if (reset_in || req_n_in) wait_reg <= 2'h0;
        else if (wait_reg != lat_in) wait_reg <= wait_reg + 2'h1;
        gnt_n_out <= reset_in | ~(park_in | (~req_n_in & (wait_reg == lat_in)));
    end
endmodule // pci_arbiter_model

// >>> tb/pci_bus_request_grant_parking_properties.sv
// Checker: port timing of request, grant and parking
module pci_bus_request_grant_parking_properties #(parameter MASTERS = 9) (
    input wire clk_sys_in,
    input wire reset_in,
    input wire pri_gnt_n_in,
    input wire sec_pending_in,
    input wire pri_frame_n_out,
    input wire pri_ad_cbe_oe_n_out,
    input wire primary_parity_oe_n_out,
    input wire [MASTERS-1:0] sec_gnt_n_out,
    input wire sec_frame_n_out,
    input wire sec_ad_cbe_oe_n_out,
    input wire sec_par_oe_n_out,
    input wire external_mode_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (reset_in);
    a_pri_par_late: assert property (
        $fell(primary_parity_oe_n_out) |-> !$past(pri_ad_cbe_oe_n_out)) else $error("par early");
    a_sec_par_late: assert property (
        $fell(sec_par_oe_n_out) |-> !$past(sec_ad_cbe_oe_n_out)) else $error("sec par early");
    a_pri_float_nogrant: assert property (
        pri_gnt_n_in [*8] |-> pri_ad_cbe_oe_n_out && primary_parity_oe_n_out)
        else $error("pri not floated");
    a_ext_gnt_high: assert property (
        external_mode_out |-> &sec_gnt_n_out[MASTERS-1:1]) else $error("spare grant low");
    a_ext_req_idle: assert property (
        (external_mode_out && !sec_pending_in) [*4] |-> sec_gnt_n_out[0])
        else $error("idle req");
    a_sec_frame_req: assert property (
        external_mode_out && $fell(sec_frame_n_out) |-> !$past(sec_gnt_n_out[0]))
        else $error("frame no req");
    a_pri_frame_pulse: assert property (
        $fell(pri_frame_n_out) |=> pri_frame_n_out) else $error("frame too long");
    a_int_one_grant: assert property (
        !external_mode_out |-> $onehot0(~sec_gnt_n_out)) else $error("two grants");
endmodule // pci_bus_request_grant_parking_properties
bind pci_bus_request_grant_parking pci_bus_request_grant_parking_properties #(.MASTERS(MASTERS))
    pci_bus_request_grant_parking_properties_inst (.clk_sys_in(clk_sys_in),
    .reset_in(reset_in), .pri_gnt_n_in(pri_gnt_n_in), .sec_pending_in(sec_pending_in),
    .pri_frame_n_out(pri_frame_n_out), .pri_ad_cbe_oe_n_out(pri_ad_cbe_oe_n_out),
    .primary_parity_oe_n_out(primary_parity_oe_n_out), .sec_gnt_n_out(sec_gnt_n_out),
    .sec_frame_n_out(sec_frame_n_out), .sec_ad_cbe_oe_n_out(sec_ad_cbe_oe_n_out),
    .sec_par_oe_n_out(sec_par_oe_n_out), .external_mode_out(external_mode_out));

// >>> tb/pci_bus_request_grant_parking_tb.sv
// Testbench for request, grant and parking logic
module pci_bus_request_grant_parking_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst = 1, strap = 0, fpark = 0, ppend = 0, spend = 0, sfrm = 1, ppark = 0;
    logic spark = 0;
    logic [8:0] sreq = 9'h1ff, sgnt;
    wire pgnt, xgnt, preq, pfo, pado, ppo, sfo, sado, spo, extm;
    int bad_count = 0, cmp_count = 0, cyc = 0, pf = 0, sf = 0;
    // Request 0 becomes the external grant once the strap is high
    pci_bus_request_grant_parking pci_bus_request_grant_parking_inst (.clk_sys_in(clk),
        .reset_in(rst), .central_function_strap_n(strap), .force_sec_park_in(fpark),
        .pri_pending_in(ppend), .pri_gnt_n_in(pgnt), .pri_frame_n_in(1'b1),
        .pri_irdy_n_in(1'b1), .sec_pending_in(spend), .sec_req_n_in({sreq[8:1],
        strap ? xgnt : sreq[0]}), .sec_frame_n_in(sfrm), .sec_irdy_n_in(sfrm),
        .pri_req_n_out(preq), .pri_frame_n_out(pfo), .pri_ad_cbe_oe_n_out(pado),
        .primary_parity_oe_n_out(ppo), .sec_gnt_n_out(sgnt), .sec_frame_n_out(sfo),
        .sec_ad_cbe_oe_n_out(sado), .sec_par_oe_n_out(spo), .external_mode_out(extm));
    pci_arbiter_model pri_arb (.clk_in(clk), .reset_in(rst), .req_n_in(preq),
        .park_in(ppark), .lat_in(2'h0), .gnt_n_out(pgnt));
    pci_arbiter_model sec_arb (.clk_in(clk), .reset_in(rst), .req_n_in(sgnt[0]),
        .park_in(spark), .lat_in(2'h3), .gnt_n_out(xgnt));
    initial forever #12.5 clk = ~clk;
    task automatic chk(input string n, input logic [8:0] e, input logic [8:0] g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic run(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Strap is only taken after reset, so each mode needs its own reset
    task automatic do_reset(input logic s);
        strap <= s;
        rst <= 1;
        run(12);
        rst <= 0;
        run(12);
    endtask
    task automatic t_pri;
        int n0;
        ppark <= 1;
        run(12);
        chk("pri park", 9'h0, {pado, ppo});
        ppark <= 0;
        run(12);
        chk("pri float", 9'h3, {pado, ppo});
        n0 = pf;
        ppend <= 1;
        run(20);
        chk("pri start", 9'h1, 9'(!preq && pf > n0));
        ppend <= 0;
        $display("pri test done");
    endtask
    task automatic t_int;
        chk("int mode", 9'h0, 9'(extm));
        sreq <= 9'h1f7;
        run(8);
        chk("no traffic", 9'h1ff, sgnt);
        sfrm <= 0;
        run(3);
        sfrm <= 1;
        run(8);
        chk("grant 3", 9'h1f7, sgnt);
        sreq <= 9'h1ff;
        run(6);
        chk("kept", 9'h1f7, sgnt);
        fpark <= 1;
        run(8);
        chk("forced", 9'h1ff, sgnt);
        fpark <= 0;
        $display("int test done");
    endtask
    task automatic t_ext;
        int n0;
        do_reset(1);
        chk("ext mode", 9'h1, 9'(extm));
        spark <= 1;
        run(12);
        chk("sec park", 9'h0, {sado, spo});
        sfrm <= 0;
        run(10);
        chk("busy", 9'h1, 9'(sado));
        sfrm <= 1;
        spark <= 0;
        spend <= 1;
        n0 = sf;
        run(4);
        chk("own req", 9'h0, 9'(sgnt[0]));
        run(16);
        chk("sec start", 9'h1, 9'(sf > n0));
        spend <= 0;
        $display("ext test done");
    endtask
    // Cycle ceiling and frame pulse counters
    always @(posedge clk) begin
        cyc++;
        pf += !pfo;
        sf += !sfo;
        if (cyc > 2000) begin
            bad_count++;
            test_done;
        end
    end
    initial begin
        run(1);
        do_reset(0);
        t_pri();
        t_int();
        t_ext();
        test_done;
    end
endmodule // pci_bus_request_grant_parking_tb
